// ### dv/prio_arb_model.sv
`timescale 1ns/1ns
// stand-in for the core arbitration: samples each per-source level
module prio_arb_model
(
  input  wire logic       clk_i,
  input  wire logic [6:0] level_i,
  output logic [6:0]      high_o
);
  // levels are taken on the core clock, so they show one cycle late
  always_ff @(posedge clk_i)
    high_o <= level_i;
endmodule : prio_arb_model

// ### dv/tb.sv
`timescale 1ns/1ns
module tb;
  logic        clk_i = 1'b0, rst_i = 1'b1, cyc_i = 1'b0, stb_i = 1'b0, we_i = 1'b0;
  logic [3:0]  adr_i = 4'h0, sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0, dat_o, rd;
  logic        ack_o;
  wire  [6:0]  lv;
  logic [6:0]  hi;
  int          num_errors = 0, checks = 0, cyc_cnt = 0;
  // clock
  always #2 clk_i = ~clk_i;
  interrupt_priority_select DUT (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .adr_i(adr_i), .we_i(we_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
    .serial_periph_prio_sel_o(lv[6]), .timer_two_prio_sel_o(lv[5]), .uart_prio_sel_o(lv[4]),
    .timer_one_prio_sel_o(lv[3]), .ext_irq_one_prio_sel_o(lv[2]),
    .timer_zero_prio_sel_o(lv[1]), .ext_irq_zero_prio_sel_o(lv[0]));
  prio_arb_model ARB (.clk_i(clk_i), .level_i(lv), .high_o(hi));
  ////////////////////////////////////////////////////////////////////////////
  task automatic test_done;
    $display("errors %0d checks %0d", num_errors, checks);
    if (num_errors == 0 && checks > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask : test_done
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : cmp
  // one classic cycle; waits for ack, no fixed latency assumed
  task automatic bus(input logic w, input logic [3:0] a, input logic [3:0] s,
                     input logic [31:0] d);
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= w;
    adr_i <= a;
    sel_i <= s;
    dat_i <= d;
    do @(posedge clk_i); while (ack_o !== 1'b1);
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
    we_i  <= 1'b0;
  endtask : bus
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    bus(1'b0, 4'h0, 4'hF, 32'h0);
    cmp(rd, 32'h0000_0080);
    cmp({25'h0, hi}, 32'h0);
    $display("test reset done");
  endtask : t_reset
  // walking one over every field, then all ones
  task automatic t_bits;
    for (int i = 0; i < 8; i++)
    begin
      bus(1'b1, 4'h0, 4'h1, 32'h1 << i);
      bus(1'b0, 4'h0, 4'hF, 32'h0);
      cmp(rd, 32'h0000_0080 | (32'h1 << i));
      cmp({25'h0, hi}, (32'h1 << i) & 32'h0000_007F);
    end
    bus(1'b1, 4'h0, 4'h1, 32'h0000_00FF);
    bus(1'b0, 4'h0, 4'hF, 32'h0);
    cmp(rd, 32'h0000_00FF);
    cmp({25'h0, hi}, 32'h0000_007F);
    $display("test bits done");
  endtask : t_bits
  // lane off and unmapped place must leave the register alone
  task automatic t_refuse;
    bus(1'b1, 4'h0, 4'hE, 32'h0000_0000);
    bus(1'b1, 4'h4, 4'h1, 32'h0000_0000);
    bus(1'b0, 4'h4, 4'hF, 32'h0);
    cmp(rd, 32'h0);
    bus(1'b0, 4'h0, 4'hF, 32'h0);
    cmp(rd, 32'h0000_00FF);
    cmp({25'h0, hi}, 32'h0000_007F);
    $display("test refuse done");
  endtask : t_refuse
  // reset in mid-run must bring back the reset pattern
  task automatic t_rerun;
    bus(1'b1, 4'h0, 4'h1, 32'h0000_007F);
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (3) @(posedge clk_i);
    rst_i <= 1'b0;
    bus(1'b0, 4'h0, 4'hF, 32'h0);
    cmp(rd, 32'h0000_0080);
    cmp({25'h0, hi}, 32'h0);
    $display("test mid reset done");
  endtask : t_rerun
  ////////////////////////////////////////////////////////////////////////////
  // hang guard, far above the hundred or so cycles the tests need
  always @(posedge clk_i)
  begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 2000)
    begin
      num_errors++;
      test_done();
    end
  end
  // main sequence
  initial
  begin
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_bits();
    t_refuse();
    t_rerun();
    test_done();
  end
endmodule : tb

// ### inc/prio_sel_pkg.sv
package prio_sel_pkg;

  // register map, byte addresses on the 32-bit bus
  localparam logic [3:0] PRIO_REG_ADDR = 4'h0;
  localparam int         ADDR_W        = 4;

  // field positions inside the priority register
  localparam int BIT_UNUSED     = 7;
  localparam int BIT_SPI        = 6;
  localparam int BIT_TIMER_TWO  = 5;
  localparam int BIT_UART       = 4;
  localparam int BIT_TIMER_ONE  = 3;
  localparam int BIT_EXT_ONE    = 2;
  localparam int BIT_TIMER_ZERO = 1;
  localparam int BIT_EXT_ZERO   = 0;

  // reset value: unused top bit reads one, all sources low priority
  localparam logic [7:0] PRIO_RESET = 8'h80;
  localparam logic [7:0] STORE_MASK = 8'h7F;

  localparam logic [31:0] UNMAPPED_DATA = 32'h0000_0000;

endpackage : prio_sel_pkg

// ### verilog/interrupt_priority_select.sv
`timescale 1ns/1ns
// Contract
// - bit 7 reads as one; writes to it are ignored.
// - bit 6 one puts the serial peripheral interrupt at high priority.
// - bit 4 one puts the uart interrupt at high priority.
// - bit 3 one puts the timer 1 interrupt at high priority.
// - bit 2 one puts external interrupt 1 at high priority.
// - bit 1 one puts the timer 0 interrupt at high priority.
// - bit 0 one puts external interrupt 0 at high priority.
module interrupt_priority_select
(
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic [prio_sel_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic                              we_i,
  input  wire logic [3:0]                        sel_i,
  input  wire logic [31:0]                       dat_i,
  output logic [31:0]                            dat_o,
  output logic                                   ack_o,
  output logic                                   serial_periph_prio_sel_o,
  output logic                                   timer_two_prio_sel_o,
  output logic                                   uart_prio_sel_o,
  output logic                                   timer_one_prio_sel_o,
  output logic                                   ext_irq_one_prio_sel_o,
  output logic                                   timer_zero_prio_sel_o,
  output logic                                   ext_irq_zero_prio_sel_o
);

  logic       hit;
  logic       wr_stb;
  logic       rd_stb;
  logic [7:0] prio_r;
  logic [7:0] prio_nxt;

  ////////////////////////////////////////////////////////////////////////
  // bus handshake
  prio_bus_slave u_slave
  (
    .clk_i    (clk_i),
    .rst_i    (rst_i),
    .cyc_i    (cyc_i),
    .stb_i    (stb_i),
    .adr_i    (adr_i),
    .we_i     (we_i),
    .sel_i    (sel_i),
    .ack_o    (ack_o),
    .hit_o    (hit),
    .wr_stb_o (wr_stb),
    .rd_stb_o (rd_stb)
  );

  ////////////////////////////////////////////////////////////////////////
  // priority register; top bit forced so it can never store a zero
  always_comb
  begin
    prio_nxt = prio_r;
    if (wr_stb && hit)
      prio_nxt = (dat_i[7:0] & prio_sel_pkg::STORE_MASK)
               | ~prio_sel_pkg::STORE_MASK;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      prio_r <= prio_sel_pkg::PRIO_RESET;
    else
      prio_r <= prio_nxt;
  end

  ////////////////////////////////////////////////////////////////////////
  // read data registered so it is steady with ack; unmapped reads zero
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      dat_o <= prio_sel_pkg::UNMAPPED_DATA;
    else if (cyc_i && stb_i && !we_i && !ack_o)
      dat_o <= hit ? {24'h000000, prio_r} : prio_sel_pkg::UNMAPPED_DATA;
  end

  ////////////////////////////////////////////////////////////////////////
  // per-source levels to the core arbitration, one means high
  assign serial_periph_prio_sel_o = prio_r[prio_sel_pkg::BIT_SPI];
  assign timer_two_prio_sel_o     = prio_r[prio_sel_pkg::BIT_TIMER_TWO];
  assign uart_prio_sel_o          = prio_r[prio_sel_pkg::BIT_UART];
  assign timer_one_prio_sel_o     = prio_r[prio_sel_pkg::BIT_TIMER_ONE];
  assign ext_irq_one_prio_sel_o   = prio_r[prio_sel_pkg::BIT_EXT_ONE];
  assign timer_zero_prio_sel_o    = prio_r[prio_sel_pkg::BIT_TIMER_ZERO];
  assign ext_irq_zero_prio_sel_o  = prio_r[prio_sel_pkg::BIT_EXT_ZERO];

  ////////////////////////////////////////////////////////////////////////
  // checks
  // shadow of the last committed write; the levels are judged one edge later
  logic                           wr_hit_r;
  logic [7:0]                     wr_dat_r;
  logic [prio_sel_pkg::BIT_SPI:0] lvl_vec;

  always_ff @(posedge clk_i)
  begin
    wr_hit_r <= wr_stb && hit && !rst_i;
    wr_dat_r <= dat_i[7:0];
  end

  // the seven levels side by side, top source first
  assign lvl_vec = {serial_periph_prio_sel_o, timer_two_prio_sel_o, uart_prio_sel_o,
                    timer_one_prio_sel_o, ext_irq_one_prio_sel_o,
                    timer_zero_prio_sel_o, ext_irq_zero_prio_sel_o};

  // fresh read request: strobed, not a write, not yet answered
  function automatic logic rd_req_new
  (
    input logic cyc,
    input logic stb,
    input logic we,
    input logic ack
  );
    return cyc && stb && !we && !ack;
  endfunction : rd_req_new

  ////////////////////////////////////////////////////////////////////////
  // register and read path

  // unused top bit can never hold a zero
  chk_top_bit_one: assert property (@(posedge clk_i) disable iff (rst_i)
    prio_r[prio_sel_pkg::BIT_UNUSED])
    else $error("top bit not one");

  // first edge out of reset shows the reset pattern
  chk_reset_value: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i)
    |-> prio_r == prio_sel_pkg::PRIO_RESET)
    else $error("register not at reset value");

  // a write lands in full on the acking edge, top bit still forced
  chk_write_commits: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && hit
    |=> lvl_vec == wr_dat_r[prio_sel_pkg::BIT_SPI:0] && prio_r[prio_sel_pkg::BIT_UNUSED])
    else $error("write did not land");

  // nothing but a mapped write may move the levels
  chk_levels_hold: assert property (@(posedge clk_i) disable iff (rst_i)
    !(wr_stb && hit)
    |=> $stable(prio_r))
    else $error("levels moved without write");

  // low lane off: the byte is not ours to take
  chk_lane_off_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && ack_o && we_i && !sel_i[0]
    |=> $stable(prio_r))
    else $error("write with lane off landed");

  // unmapped writes are acked but dropped
  chk_unmapped_wr_ignored: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_stb && !hit
    |=> $stable(prio_r))
    else $error("unmapped write landed");

  // reads have no side effects
  chk_read_keeps_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb
    |=> $stable(prio_r))
    else $error("read moved the register");

  // the top bit reads back as one
  chk_read_top_bit: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && hit
    |-> dat_o[prio_sel_pkg::BIT_UNUSED])
    else $error("top bit read as zero");

  // read data is the register as it stands
  chk_read_mirrors_reg: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && hit
    |-> dat_o[prio_sel_pkg::BIT_UNUSED:0] == prio_r)
    else $error("read data differs from register");

  // only the low lane carries data
  chk_read_upper_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb
    |-> dat_o[31:prio_sel_pkg::BIT_UNUSED+1] == 24'h000000)
    else $error("upper read lanes not zero");

  // unmapped places read as zero, so software sees a hole, not an alias
  chk_unmapped_read_zero: assert property (@(posedge clk_i) disable iff (rst_i)
    rd_stb && !hit
    |-> dat_o == prio_sel_pkg::UNMAPPED_DATA)
    else $error("unmapped read not zero");

  // read data stands until the next read is taken
  chk_data_holds: assert property (@(posedge clk_i) disable iff (rst_i)
    !rd_req_new(cyc_i, stb_i, we_i, ack_o)
    |=> $stable(dat_o))
    else $error("read data moved without read");

  // a write must not disturb the last read data
  chk_write_keeps_data: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && we_i
    |=> $stable(dat_o))
    else $error("write moved read data");

  ////////////////////////////////////////////////////////////////////////
  // per-source levels, judged one edge after the write

  // every source starts at low priority
  chk_reset_levels_low: assert property (@(posedge clk_i) disable iff (rst_i)
    $past(rst_i)
    |-> lvl_vec == prio_sel_pkg::PRIO_RESET[prio_sel_pkg::BIT_SPI:0])
    else $error("levels not low after reset");

  // serial peripheral level follows its bit
  chk_spi_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> serial_periph_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_SPI])
    else $error("spi level wrong");

  // timer 2 level follows its bit
  chk_t2_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> timer_two_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_TIMER_TWO])
    else $error("timer 2 level wrong");

  // uart level follows its bit
  chk_uart_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> uart_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_UART])
    else $error("uart level wrong");

  // timer 1 level follows its bit
  chk_t1_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> timer_one_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_TIMER_ONE])
    else $error("timer 1 level wrong");

  // external interrupt 1 level follows its bit
  chk_x1_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> ext_irq_one_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_EXT_ONE])
    else $error("ext 1 level wrong");

  // timer 0 level follows its bit
  chk_t0_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> timer_zero_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_TIMER_ZERO])
    else $error("timer 0 level wrong");

  // external interrupt 0 level follows its bit
  chk_x0_level: assert property (@(posedge clk_i) disable iff (rst_i)
    wr_hit_r
    |-> ext_irq_zero_prio_sel_o == wr_dat_r[prio_sel_pkg::BIT_EXT_ZERO])
    else $error("ext 0 level wrong");

  ////////////////////////////////////////////////////////////////////////
  // bus handshake: one wait state, one-cycle ack

  // a fresh request is answered on the next edge
  chk_ack_one_wait: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o
    |=> ack_o)
    else $error("ack late");

  // ack drops after one cycle; a request still held is acked again one edge after the drop
  chk_ack_single_pulse: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |=> !ack_o)
    else $error("ack longer than one cycle");

  // no ack without a request one edge before
  chk_ack_needs_req: assert property (@(posedge clk_i) disable iff (rst_i)
    ack_o
    |-> $past(cyc_i) && $past(stb_i))
    else $error("ack without request");

  // an idle bus keeps ack low
  chk_ack_idle_low: assert property (@(posedge clk_i) disable iff (rst_i)
    !(cyc_i && stb_i)
    |=> !ack_o)
    else $error("ack on idle bus");

  // refused places are still answered, so the master never hangs
  chk_ack_unmapped_too: assert property (@(posedge clk_i) disable iff (rst_i)
    cyc_i && stb_i && !ack_o && !hit
    |=> ack_o)
    else $error("unmapped access not acked");

  ////////////////////////////////////////////////////////////////////////
  // main scenarios

  // a committed write to the register
  cov_write: cover property (@(posedge clk_i)
    wr_stb && hit);

  // a read of the register
  cov_read: cover property (@(posedge clk_i)
    rd_stb && hit);

  // a read of an unmapped place
  cov_unmapped: cover property (@(posedge clk_i)
    rd_stb && !hit);

  // a write with the low lane switched off
  cov_lane_off: cover property (@(posedge clk_i)
    cyc_i && stb_i && ack_o && we_i && !sel_i[0]);

  // every source at high priority at once
  cov_all_high: cover property (@(posedge clk_i)
    lvl_vec == prio_sel_pkg::STORE_MASK[prio_sel_pkg::BIT_SPI:0]);

endmodule : interrupt_priority_select

// ### verilog/prio_bus_slave.sv
`timescale 1ns/1ns
module prio_bus_slave
(
  input  wire logic                              clk_i,
  input  wire logic                              rst_i,
  input  wire logic                              cyc_i,
  input  wire logic                              stb_i,
  input  wire logic [prio_sel_pkg::ADDR_W-1:0]   adr_i,
  input  wire logic                              we_i,
  input  wire logic [3:0]                        sel_i,
  output logic                                   ack_o,
  output logic                                   hit_o,
  output logic                                   wr_stb_o,
  output logic                                   rd_stb_o
);

  // one wait state: ack follows request by one cycle, then drops
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ack_o <= 1'b0;
    else
      ack_o <= cyc_i && stb_i && !ack_o;
  end

  // address decode, shared by read mux and write strobe
  assign hit_o    = (adr_i == prio_sel_pkg::PRIO_REG_ADDR);
  // write commits on the acking edge, lowest lane only
  assign wr_stb_o = cyc_i && stb_i && ack_o && we_i && sel_i[0];
  assign rd_stb_o = cyc_i && stb_i && ack_o && !we_i;

endmodule : prio_bus_slave
